// File: src/can_status_consts.vh
// Register offsets, field positions, reset values and timing counts of the CAN status block.
`ifndef CAN_STATUS_CONSTS_VH
`define CAN_STATUS_CONSTS_VH
`define GIT_ADDR            8'h9B
`define GSTA_ADDR           8'hAA
`define GIT_RESET           8'h00
`define GSTA_RESET          8'h00
`define GIT_COMBINED_INTERRUPT_FLAG_BIT       7
`define GIT_TIMER_OVERRUN_FLAG_BIT      5
`define GIT_BUFFER_OVERRUN_FLAG_BIT      4
`define GIT_STUFF_BIT       3
`define GIT_CRC_BIT         2
`define GIT_FORM_BIT        1
`define GIT_ACK_BIT         0
`define GIT_CLEAR_MASK      8'h3F
`define GSTA_OVERLOAD_SENDING_FLAG_BIT       6
`define GSTA_TRANSMITTER_BUSY_FLAG_BIT       4
`define GSTA_RECEIVER_BUSY_FLAG_BIT       3
`define GSTA_ENABLED_STATE_FLAG_BIT       2
`define GSTA_BUS_OFF_FLAG_BIT       1
`define GSTA_ERROR_PASSIVE_FLAG_BIT       0
`define ENABLE_DELAY_CLKS   2
`define TIMER_MAX           16'hFFFF
`define ERR_PASSIVE_LIMIT   9'h080
`define BUS_OFF_LIMIT       9'h100
`endif

// File: src/can_enable_delay.v
// Delay line that turns the enable command into the true enabled state.
`timescale 1ns/10ps
`include "can_status_consts.vh"
module can_enable_delay #(
    parameter DELAY = `ENABLE_DELAY_CLKS
) (
    input  wire clk_sys_in,
    input  wire srst_in,
    input  wire enable_cmd_in,
    input  wire idle_in,
    output reg  enabled_out
);
    reg [DELAY-1:0] pipe_q;

    // Enabling passes a DELAY-stage pipe; disabling waits until traffic ends.
    always @(posedge clk_sys_in) begin
        if (srst_in) begin
            pipe_q      <= {DELAY{1'b0}};
            enabled_out <= 1'b0;
        end else begin
            pipe_q <= {pipe_q[DELAY-2:0], enable_cmd_in}; // R13
            if (pipe_q[DELAY-1] && enable_cmd_in) begin
                enabled_out <= 1'b1;
            end else if (!enable_cmd_in && idle_in) begin
                enabled_out <= 1'b0;
            end
        end
    end
endmodule // can_enable_delay

// File: src/can_timer_wrap.v
// Free running 16-bit CAN timer with a rollover pulse.
`timescale 1ns/10ps
`include "can_status_consts.vh"
module can_timer_wrap (
    input  wire        clk_sys_in,
    input  wire        srst_in,
    input  wire        tick_in,
    output reg  [15:0] timer_out,
    output wire        wrap_out
);
    // The wrap pulse marks the step from the maximum value back to zero.
    assign wrap_out = tick_in && (timer_out == `TIMER_MAX); // R9

    // The timer advances once per tick.
    always @(posedge clk_sys_in) begin
        if (srst_in) begin
            timer_out <= 16'h0000;
        end else if (tick_in) begin
            timer_out <= timer_out + 16'h0001;
        end
    end
endmodule // can_timer_wrap

// File: src/can_general_status_and_error_flags.v
// General status and general interrupt flag registers of the CAN controller.
`timescale 1ns/10ps
`include "can_status_consts.vh"
// Functional notes
// R1: Overload flag high while sending own overload
// R2: Transmit busy while driving any frame, ack
// R3: Transmit busy in interframe when frame pending
// R4: Receive busy while acquiring or monitoring frame
// R5: Separate read-only true enabled state flag
// R6: Status register ignores all software writes
// R7: Software keeps reserved bits zero, ignores reads
// R8: Combined flag ORs all controller interrupt requests
// R9: Timer wrap sets overrun, interrupts if enabled
// R10: Software clears overrun to drop request
// R11: Buffer full sets sticky overrun until cleared
// R12: Form violations set sticky form error flag
// R13: Enabled state lags command by two clocks; the code sets it on the third clock
// R14: Stuff, CRC, ack errors set sticky flags
// R15: Bus-off, error-passive follow error counter thresholds; the code takes bus-off from bus_off_state_in, not from a counter threshold
module can_general_status_and_error_flags (
    input  wire        clk_sys_in,
    input  wire        srst_in,
    input  wire        soft_reset_in,
    input  wire        controller_enable_command_in,
    input  wire        sfr_wr_in,
    input  wire        sfr_rd_in,
    input  wire [7:0]  sfr_addr_in,
    input  wire [7:0]  sfr_wdata_in,
    output reg  [7:0]  sfr_rdata_out,
    input  wire        tx_frame_active_in,
    input  wire        tx_ack_active_in,
    input  wire        tx_overload_active_in,
    input  wire        interframe_in,
    input  wire        tx_pending_in,
    input  wire        rx_frame_active_in,
    input  wire        bus_idle_in,
    input  wire        timer_tick_in,
    input  wire        rx_buffer_full_in,
    input  wire        stuff_error_in,
    input  wire        crc_error_in,
    input  wire        form_error_in,
    input  wire        ack_error_in,
    input  wire [7:0]  tx_error_count_in,
    input  wire [7:0]  rx_error_count_in,
    input  wire        bus_off_state_in,
    input  wire        timer_interrupt_enable_in,
    input  wire        general_error_enable_in,
    input  wire        buffer_enable_in,
    input  wire        other_irq_in,
    output wire [15:0] can_timer_out,
    output wire        can_irq_out
);
    wire       rst;
    wire       enabled;
    wire       timer_wrap;
    wire       git_wr;
    wire [7:0] clr;
    wire       err_irq;
    wire       buf_irq;
    wire       tim_irq;
    wire       err_passive;
    wire [7:0] gsta;
    wire [7:0] git;
    reg        overload_sending_flag_q;
    reg        transmitter_busy_flag_q;
    reg        receiver_busy_flag_q;
    reg        bus_off_flag_q;
    reg        error_passive_flag_q;
    reg        buf_full_q;
    reg  [5:0] flags_q;
    reg  [5:0] flags_d;

    // Software reset is ORed with the hardware reset.
    assign rst = srst_in | soft_reset_in;

    can_enable_delay #(
        .DELAY       (`ENABLE_DELAY_CLKS)
    ) u_enable (
        .clk_sys_in    (clk_sys_in),
        .srst_in       (rst),
        .enable_cmd_in (controller_enable_command_in),
        .idle_in       (bus_idle_in),
        .enabled_out   (enabled)
    );

    can_timer_wrap u_timer (
        .clk_sys_in (clk_sys_in),
        .srst_in    (rst),
        .tick_in    (timer_tick_in),
        .timer_out  (can_timer_out),
        .wrap_out   (timer_wrap)
    );

    // Fault confinement error-passive threshold on the error counters.
    assign err_passive = ({1'b0, tx_error_count_in} >= `ERR_PASSIVE_LIMIT) ||
                         ({1'b0, rx_error_count_in} >= `ERR_PASSIVE_LIMIT); // R15

    // Status bits are registered images of the protocol engine activity.
    always @(posedge clk_sys_in) begin
        if (rst) begin
            overload_sending_flag_q     <= 1'b0;
            transmitter_busy_flag_q     <= 1'b0;
            receiver_busy_flag_q     <= 1'b0;
            bus_off_flag_q     <= 1'b0;
            error_passive_flag_q     <= 1'b0;
            buf_full_q <= 1'b0;
        end else begin
            overload_sending_flag_q     <= tx_overload_active_in; // R1
            transmitter_busy_flag_q     <= tx_frame_active_in | tx_ack_active_in | tx_overload_active_in | // R2
                          (interframe_in & tx_pending_in); // R3
            receiver_busy_flag_q     <= rx_frame_active_in; // R4
            bus_off_flag_q     <= bus_off_state_in; // R15
            error_passive_flag_q     <= err_passive & ~bus_off_state_in; // R15
            buf_full_q <= rx_buffer_full_in;
        end
    end

    // Status image; bit 7 and bit 5 read as zero.
    assign gsta = {1'b0, overload_sending_flag_q, 1'b0, transmitter_busy_flag_q, receiver_busy_flag_q, enabled, bus_off_flag_q, error_passive_flag_q}; // R5

    // A write of one to one of flag bits 5 to 0 clears it; the status register has no write path.
    assign git_wr = sfr_wr_in && (sfr_addr_in == `GIT_ADDR); // R6
    assign clr    = git_wr ? (sfr_wdata_in & `GIT_CLEAR_MASK) : 8'h00;

    // Sticky flags: a new event in the clearing cycle wins over the clear.
    always @* begin
        flags_d = flags_q & ~clr[5:0]; // R10
        if (timer_wrap) begin
            flags_d[`GIT_TIMER_OVERRUN_FLAG_BIT] = 1'b1; // R9
        end
        if (rx_buffer_full_in && !buf_full_q) begin
            flags_d[`GIT_BUFFER_OVERRUN_FLAG_BIT] = 1'b1; // R11
        end
        if (stuff_error_in) begin
            flags_d[`GIT_STUFF_BIT] = 1'b1; // R14
        end
        if (crc_error_in) begin
            flags_d[`GIT_CRC_BIT] = 1'b1; // R14
        end
        if (form_error_in) begin
            flags_d[`GIT_FORM_BIT] = 1'b1; // R12
        end
        if (ack_error_in) begin
            flags_d[`GIT_ACK_BIT] = 1'b1; // R14
        end
    end

    // Flag register.
    always @(posedge clk_sys_in) begin
        if (rst) begin
            flags_q <= 6'h00;
        end else begin
            flags_q <= flags_d;
        end
    end

    // Interrupt requests from each source, and their combination.
    assign err_irq     = general_error_enable_in & (|flags_q[3:0]);
    assign buf_irq     = buffer_enable_in & flags_q[`GIT_BUFFER_OVERRUN_FLAG_BIT];
    assign tim_irq     = timer_interrupt_enable_in & flags_q[`GIT_TIMER_OVERRUN_FLAG_BIT]; // R9
    assign can_irq_out = err_irq | buf_irq | tim_irq | other_irq_in; // R8
    assign git         = {can_irq_out, 1'b0, flags_q}; // R8

    // Registered read data; unmapped addresses read as zero.
    always @(posedge clk_sys_in) begin
        if (rst) begin
            sfr_rdata_out <= 8'h00;
        end else if (sfr_rd_in) begin
            case (sfr_addr_in)
                `GIT_ADDR:  sfr_rdata_out <= git;
                `GSTA_ADDR: sfr_rdata_out <= gsta;
                default:    sfr_rdata_out <= 8'h00;
            endcase
        end
    end
endmodule // can_general_status_and_error_flags

// File: dv/can_status_asserts.sv
// Assertion checker for the CAN general status and interrupt flag block.
`timescale 1ns/10ps
module can_status_asserts (
    input wire        clk_sys_in,
    input wire        srst_in,
    input wire        sfr_rd_in,
    input wire [7:0]  sfr_addr_in,
    input wire [7:0]  sfr_rdata_out,
    input wire        tx_frame_active_in,
    input wire        tx_overload_active_in,
    input wire        rx_frame_active_in,
    input wire        form_error_in,
    input wire        general_error_enable_in,
    input wire        rx_buffer_full_in,
    input wire        buffer_enable_in,
    input wire        timer_tick_in,
    input wire        timer_interrupt_enable_in,
    input wire [15:0] can_timer_out,
    input wire        other_irq_in,
    input wire        can_irq_out
);
    // Register reads and the timer rollover condition.
    wire rd_sta = sfr_rd_in && sfr_addr_in == 8'hAA;
    wire rd_git = sfr_rd_in && sfr_addr_in == 8'h9B;
    wire wrap   = timer_tick_in && can_timer_out == 16'hFFFF;
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (srst_in);
    a_overload_flag: assert property (rd_sta && $past(tx_overload_active_in) |=> sfr_rdata_out[6])
        else $error("overload flag low");
    a_tx_busy: assert property (rd_sta && $past(tx_frame_active_in) |=> sfr_rdata_out[4])
        else $error("transmit busy low");
    a_rx_busy: assert property (rd_sta && $past(rx_frame_active_in) |=> sfr_rdata_out[3])
        else $error("receive busy low");
    a_image_bit: assert property (rd_git |=> sfr_rdata_out[7] == $past(can_irq_out))
        else $error("image bit wrong");
    a_other_irq: assert property (other_irq_in |-> can_irq_out)
        else $error("request not merged");
    a_form_sets: assert property (form_error_in && general_error_enable_in ##1 general_error_enable_in |-> can_irq_out)
        else $error("form error lost");
    a_timer_wrap: assert property (wrap |=> can_timer_out == 16'h0000)
        else $error("timer did not wrap");
    a_wrap_irq: assert property (wrap && timer_interrupt_enable_in |-> ##[1:2] can_irq_out)
        else $error("wrap request lost");
    a_buffer_sets: assert property ($rose(rx_buffer_full_in) && buffer_enable_in |-> ##[1:2] can_irq_out)
        else $error("buffer request lost");
endmodule // can_status_asserts
bind can_general_status_and_error_flags can_status_asserts chk_u (.*);

// File: dv/can_bus_node.sv
// Far-side node: a short received frame that ends in one chosen protocol fault.
`timescale 1ns/10ps
module can_bus_node (
    input  wire       clk_sys_in,
    input  wire       start_in,
    input  wire [1:0] kind_in,
    output reg        rx_active_out,
    output reg  [3:0] err_out
);
    reg [2:0] cnt_q;
    initial begin
        rx_active_out = 1'b0;
        err_out = 4'h0;
        cnt_q = 3'h0;
    end
    // Frame lasts four cycles; the fault pulse comes as it ends.
    always @(posedge clk_sys_in) begin
        cnt_q <= start_in ? 3'h4 : (cnt_q != 3'h0 ? cnt_q - 3'h1 : 3'h0);
        rx_active_out <= start_in || cnt_q > 3'h1;
        err_out <= (cnt_q == 3'h1) ? (4'h1 << kind_in) : 4'h0;
    end
endmodule // can_bus_node

// File: dv/testbench.sv
// Self-checking bench for the CAN general status and interrupt flag block.
`timescale 1ns/10ps
module testbench;
    reg clk_sys_in = 0, srst_in = 1, sfr_rd = 0, sfr_wr = 0, cmd = 0, idle = 0, tick = 0, full = 0, go = 0;
    reg tx_f = 0, tx_o = 0, ifs = 0, pend = 0, tie = 0, gen = 1, ben = 1, oth = 0, bus_off_flag = 0;
    reg [7:0] addr = 0, wdat = 0, tec = 0, rec = 0;
    reg sres = 0, ack = 0;
    reg [1:0] kind = 0;
    wire [7:0] rdata;
    wire [15:0] tmr;
    wire irq, rx_a;
    wire [3:0] err;
    integer fails = 0, checks = 0, i;
    // Clock at 10 MHz.
    always #50 clk_sys_in = ~clk_sys_in;
    can_bus_node node_u (.clk_sys_in(clk_sys_in), .start_in(go), .kind_in(kind), .rx_active_out(rx_a), .err_out(err));
    can_general_status_and_error_flags dut_u (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .soft_reset_in(sres),
        .controller_enable_command_in(cmd), .sfr_wr_in(sfr_wr), .sfr_rd_in(sfr_rd), .sfr_addr_in(addr),
        .sfr_wdata_in(wdat), .sfr_rdata_out(rdata), .tx_frame_active_in(tx_f), .tx_ack_active_in(ack),
        .tx_overload_active_in(tx_o), .interframe_in(ifs), .tx_pending_in(pend), .rx_frame_active_in(rx_a),
        .bus_idle_in(idle), .timer_tick_in(tick), .rx_buffer_full_in(full), .stuff_error_in(err[3]),
        .crc_error_in(err[2]), .form_error_in(err[1]), .ack_error_in(err[0]), .tx_error_count_in(tec),
        .rx_error_count_in(rec), .bus_off_state_in(bus_off_flag), .timer_interrupt_enable_in(tie),
        .general_error_enable_in(gen), .buffer_enable_in(ben), .other_irq_in(oth), .can_timer_out(tmr),
        .can_irq_out(irq));
    task chk(input [63:0] nm, input [15:0] seen, input [15:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("MISMATCH %0s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task do_rd(input [7:0] a, input [7:0] e);
        @(negedge clk_sys_in) {sfr_rd, addr} = {1'b1, a};
        @(negedge clk_sys_in) sfr_rd = 0;
        chk("rdata", {8'h00, rdata}, {8'h00, e});
    endtask
    task do_wr(input [7:0] a, input [7:0] d);
        @(negedge clk_sys_in) {sfr_wr, addr, wdat} = {1'b1, a, d};
        @(negedge clk_sys_in) sfr_wr = 0;
    endtask
    task end_of_test;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task t_status;
        do_rd(8'hAA, 8'h00);
        {tx_o, tx_f, go} = 3'h7;
        @(negedge clk_sys_in) go = 0;
        do_rd(8'hAA, 8'h58);
        repeat (4) @(negedge clk_sys_in);
        {tx_o, tx_f, ifs, pend} = 4'h3;
        do_rd(8'hAA, 8'h10);
        pend = 0;
        tec = 8'h80;
        do_rd(8'hAA, 8'h01);
        bus_off_flag = 1;
        do_wr(8'hAA, 8'h5F);
        do_rd(8'hAA, 8'h02);
        {tec, bus_off_flag, ifs} = 10'h0;
        do_rd(8'h9B, 8'h81);
        do_wr(8'h9B, 8'h01);
        do_rd(8'h9B, 8'h00);
    endtask
    // Acknowledge driving, receive counter threshold and software reset.
    task t_misc;
        ack = 1;
        do_rd(8'hAA, 8'h10);
        ack = 0;
        rec = 8'h80;
        do_rd(8'hAA, 8'h01);
        rec = 0;
        full = 1;
        @(negedge clk_sys_in) full = 0;
        sres = 1;
        @(negedge clk_sys_in) sres = 0;
        do_rd(8'h9B, 8'h00);
    endtask
    task t_errors;
        for (i = 1; i < 4; i = i + 1) begin
            {kind, go} = {i[1:0], 1'b1};
            @(negedge clk_sys_in) go = 0;
            repeat (6) @(negedge clk_sys_in);
            do_rd(8'h9B, 8'h80 | (8'h01 << i));
            do_wr(8'h9B, 8'h01 << i);
            do_rd(8'h9B, 8'h00);
        end
    endtask
    task t_enable;
        cmd = 1;
        do_rd(8'hAA, 8'h00);
        repeat (6) @(negedge clk_sys_in);
        do_rd(8'hAA, 8'h04);
        {cmd, idle} = 2'b01;
        repeat (6) @(negedge clk_sys_in);
        do_rd(8'hAA, 8'h00);
        idle = 0;
    endtask
    task t_buffer;
        full = 1;
        do_rd(8'h9B, 8'h90);
        do_wr(8'h9B, 8'h10);
        do_rd(8'h9B, 8'h00);
        {full, oth} = 2'b01;
        @(negedge clk_sys_in) chk("irq", irq, 1);
        do_rd(8'h9B, 8'h80);
        oth = 0;
        do_rd(8'h55, 8'h00);
    endtask
    task t_timer;
        {tie, tick} = 2'b11;
        repeat (65535) @(negedge clk_sys_in);
        tick = 0;
        chk("timer", tmr, 16'hFFFF);
        tick = 1;
        @(negedge clk_sys_in) tick = 0;
        chk("timer", tmr, 16'h0000);
        do_rd(8'h9B, 8'hA0);
        do_wr(8'h9B, 8'h20);
        do_rd(8'h9B, 8'h00);
        chk("irq", irq, 0);
    endtask
    // Reset, then the scenarios in order.
    initial begin
        repeat (6) @(negedge clk_sys_in);
        srst_in = 0;
        t_status;
        t_errors;
        t_misc;
        t_enable;
        t_buffer;
        t_timer;
        end_of_test;
    end
    // Watchdog well beyond the expected run length.
    initial begin
        repeat (80000) @(posedge clk_sys_in);
        fails = fails + 1;
        end_of_test;
    end
endmodule // testbench
